/* File: scfg_decoder.sv */
`timescale 1ns/100ps
// How it works
// - Control bit 15 selects configuration mode.
// - Bit 14 set turns antiresonance off.
// - Stall detect needs encoder and resolution.
// - Bit 11 makes proximity flag gate homing.
// - Gated, no proximity means home edges ignored.
// - Starting speed 1 to 1,999,999 else rejected.
// - Encoder resolution 1024/2048/4096, absolute 2048.
// - Run current 1 to 34 tenths amp.
// - Bit 10 enables encoder, needs resolution.
// - Speed upper is thousands, lower remainder.
module scfg_decoder (
   // Clock and reset.
   input  wire logic                        clk,
   input  wire logic                        nrst,
   // Host output-image word port.
   input  wire logic                        img_wr,
   input  wire logic [scfg_pkg::ADDR_W-1:0] img_addr,
   input  wire logic [scfg_pkg::WORD_W-1:0] img_data,
   input  wire logic [scfg_pkg::ADDR_W-1:0] img_rd_addr,
   output logic      [scfg_pkg::WORD_W-1:0] img_rd_data,
   // Host apply request and drive options.
   input  wire logic                        apply,
   input  wire logic                        enc_absolute,
   // Homing inputs.
   input  wire logic                        prox_flag,
   input  wire logic                        home_switch,
   // Decoded configuration.
   output logic                             config_mode,
   output logic                             cfg_valid,
   output logic                             cfg_reject,
   output logic      [scfg_pkg::ERR_W-1:0]  cfg_errors,
   output logic                             resonance_comp_on,
   output logic                             stall_detect_on,
   output logic                             encoder_on,
   output logic                             proximity_gate_on_field,
   output logic      [31:0]                 start_speed,
   output logic      [scfg_pkg::WORD_W-1:0] steps_turn,
   output logic      [scfg_pkg::WORD_W-1:0] enc_counts,
   output logic      [scfg_pkg::WORD_W-1:0] idle_pct,
   output logic      [scfg_pkg::WORD_W-1:0] run_cur,
   output logic                             home_event
);
   import scfg_pkg::*;

   // ------------------------------------------------------------
   // State.
   // ------------------------------------------------------------
   typedef struct packed {
      logic [IMAGE_WORDS-1:0][WORD_W-1:0] img;
      logic [WORD_W-1:0]                  ctrl;
      logic                               valid;
      logic                               reject;
      logic [ERR_W-1:0]                   errs;
      logic [31:0]                        speed;
      logic [WORD_W-1:0]                  steps;
      logic [WORD_W-1:0]                  enc;
      logic [WORD_W-1:0]                  idle;
      logic [WORD_W-1:0]                  cur;
      logic [2:0]                         home_sync;
      logic                               home_seen;
      logic                               home_ev;
   } scfg_dec_type;

   scfg_dec_type state;
   scfg_dec_type next_state;

   // Combines the two decimal halves into one step rate.
   function automatic logic [31:0] join_speed(input logic [WORD_W-1:0] up,
                                             input logic [WORD_W-1:0] lo);
      join_speed = 32'(up) * 32'(SPEED_SCALE) + 32'(lo);
   endfunction : join_speed

   // Inclusive range test reused by several checks.
   function automatic logic in_range(input logic [WORD_W-1:0] v,
                                     input logic [WORD_W-1:0] lo,
                                     input logic [WORD_W-1:0] hi);
      in_range = (v >= lo) && (v <= hi);
   endfunction : in_range

   // Image store mirror for host read-back of written words.
   scfg_image_mem u_mem (
      .clk     (clk),
      .nrst    (nrst),
      .wr_en   (img_wr),
      .wr_addr (img_addr),
      .wr_data (img_data),
      .rd_addr (img_rd_addr),
      .rd_data (img_rd_data)
   );

   // ------------------------------------------------------------
   // Checks on the staged image.
   // ------------------------------------------------------------
   logic [ERR_W-1:0] chk;
   logic [31:0]      cand_speed;
   logic [WORD_W-1:0] c0;

   always_comb begin
      c0         = state.img[OFF_CONTROL];
      cand_speed = join_speed(state.img[OFF_SPEED_UP],
                              state.img[OFF_SPEED_LO]);
      chk = '0;
      chk[ERR_SPEED] = (cand_speed < SPEED_MIN)
                    || (cand_speed > SPEED_MAX);
      chk[ERR_SPEED_FMT] = state.img[OFF_SPEED_LO] > SPEED_LO_MAX;
      chk[ERR_STEPS] = !in_range(state.img[OFF_STEPS],
                                 STEPS_MIN, STEPS_MAX);
      chk[ERR_IDLE]  = state.img[OFF_IDLE_PCT] > IDLE_PCT_MAX;
      chk[ERR_RUN_CUR] = !in_range(state.img[OFF_RUN_CUR],
                                   RUN_CUR_MIN, RUN_CUR_MAX);
      // Resolution only matters once the encoder is enabled.
      if (c0[BIT_ENC_EN]) begin
         if (enc_absolute) begin
            chk[ERR_ENC_RES] = state.img[OFF_ENC_RES] != ENC_RES_2K;
         end else begin
            chk[ERR_ENC_RES] = (state.img[OFF_ENC_RES] != ENC_RES_1K)
                            && (state.img[OFF_ENC_RES] != ENC_RES_2K)
                            && (state.img[OFF_ENC_RES] != ENC_RES_4K);
         end
      end
      chk[ERR_STALL] = c0[BIT_STALL_EN] && !c0[BIT_ENC_EN];
      // Reserved content is flagged rather than trusted.
      chk[ERR_RESERVED] = ((c0 & CTRL_RSVD_MASK) != WORD_RESET)
                       || (state.img[OFF_RSVD_A] != WORD_RESET)
                       || (state.img[OFF_RSVD_B] != WORD_RESET);
   end

   // ------------------------------------------------------------
   // Next state.
   // ------------------------------------------------------------
   always_comb begin
      next_state = state;
      next_state.home_ev = 1'b0;
      if (img_wr && (img_addr < ADDR_W'(IMAGE_WORDS))) begin
         next_state.img[img_addr] = img_data;
      end
      // Mode follows control word straight away so the host can leave.
      if (img_wr && (img_addr == OFF_CONTROL)) begin
         next_state.ctrl[BIT_MODE] = img_data[BIT_MODE];
      end
      // Apply only in configuration mode; a bad image keeps the old set.
      if (apply && state.ctrl[BIT_MODE]) begin
         next_state.errs = chk;
         if (chk == '0) begin
            next_state.valid  = 1'b1;
            next_state.reject = 1'b0;
            next_state.ctrl   = state.img[OFF_CONTROL];
            next_state.speed  = cand_speed;
            next_state.steps  = state.img[OFF_STEPS];
            next_state.enc    = state.img[OFF_ENC_RES];
            next_state.idle   = state.img[OFF_IDLE_PCT];
            next_state.cur    = state.img[OFF_RUN_CUR];
         end else begin
            next_state.reject = 1'b1;
         end
      end
      // Home switch: three-stage sync, rise counted when 2 and 3 agree.
      next_state.home_sync = {state.home_sync[1:0], home_switch};
      if (state.home_sync[2] == state.home_sync[1]) begin
         next_state.home_seen = state.home_sync[2];
         if (state.home_sync[2] && !state.home_seen) begin
            // Gated homing drops edges unless proximity is asserted.
            next_state.home_ev = !(state.ctrl[BIT_PROX_GATE]
                                   && !prox_flag);
         end
      end
   end

   // Registered state.
   always_ff @(posedge clk) begin
      if (!nrst) begin
         state <= '0;
      end else begin
         state <= next_state;
      end
   end

   // ------------------------------------------------------------
   // Outputs.
   // ------------------------------------------------------------
   assign config_mode             = state.ctrl[BIT_MODE];
   assign cfg_valid               = state.valid;
   assign cfg_reject              = state.reject;
   assign cfg_errors              = state.errs;
   assign resonance_comp_on       = !state.ctrl[BIT_RES_OFF];
   assign encoder_on              = state.ctrl[BIT_ENC_EN];
   assign stall_detect_on         = state.ctrl[BIT_STALL_EN]
                                 && state.ctrl[BIT_ENC_EN];
   assign proximity_gate_on_field = state.ctrl[BIT_PROX_GATE];
   assign start_speed             = state.speed;
   assign steps_turn              = state.steps;
   assign enc_counts              = state.enc;
   assign idle_pct                = state.idle;
   assign run_cur                 = state.cur;
   assign home_event              = state.home_ev;

   // ------------------------------------------------------------
   // Checks.
   // ------------------------------------------------------------
   speed_bound_a: assert property (
      @(posedge clk) disable iff (!nrst)
      cfg_valid |-> (start_speed >= SPEED_MIN && start_speed <= SPEED_MAX))
      else $error("applied speed out of range");
   run_cur_a: assert property (
      @(posedge clk) disable iff (!nrst)
      cfg_valid |-> (run_cur >= RUN_CUR_MIN && run_cur <= RUN_CUR_MAX))
      else $error("applied run current out of range");
   // Stall detection needs the encoder and a legal resolution behind it.
   stall_enc_a: assert property (
      @(posedge clk) disable iff (!nrst)
      stall_detect_on |-> (encoder_on
                           && (enc_counts == ENC_RES_1K
                               || enc_counts == ENC_RES_2K
                               || enc_counts == ENC_RES_4K)))
      else $error("stall detect without encoder");
   // The gate and the flag are those seen when the pulse was formed.
   gate_home_a: assert property (
      @(posedge clk) disable iff (!nrst)
      ($past(proximity_gate_on_field) && !$past(prox_flag)) |-> !home_event)
      else $error("home edge passed without proximity");
   reject_keep_a: assert property (
      @(posedge clk) disable iff (!nrst)
      (apply && config_mode && chk != '0)
      |=> cfg_reject && $stable(start_speed))
      else $error("bad image changed settings");
   cmd_apply_a: assert property (
      @(posedge clk) disable iff (!nrst)
      (apply && !config_mode) |=> $stable(cfg_errors))
      else $error("apply taken in command mode");
   // A good apply must carry the staged bit 14 into the drive, inverted.
   res_off_a: assert property (
      @(posedge clk) disable iff (!nrst)
      (apply && config_mode && chk == '0)
      |=> resonance_comp_on == !$past(c0[BIT_RES_OFF]))
      else $error("antiresonance polarity wrong");
   steps_idle_a: assert property (
      @(posedge clk) disable iff (!nrst)
      cfg_valid |-> (in_range(steps_turn, STEPS_MIN, STEPS_MAX)
                     && idle_pct <= IDLE_PCT_MAX))
      else $error("applied steps or idle out of range");
endmodule : scfg_decoder

/* File: scfg_host_model.sv */
`timescale 1ns/100ps
// ------------------------------------------------------------
// Host model that writes the configuration image.
// ------------------------------------------------------------
module scfg_host_model (
   // Clock.
   input  wire logic                        clk,
   // Image write port and apply pulse.
   output logic                             img_wr,
   output logic      [scfg_pkg::ADDR_W-1:0] img_addr,
   output logic      [scfg_pkg::WORD_W-1:0] img_data,
   output logic                             apply
);
   import scfg_pkg::*;

   // The host sits idle until a scenario asks it to send.
   initial begin
      img_wr   = 1'b0;
      img_addr = 4'h0;
      img_data = 16'h0000;
      apply    = 1'b0;
   end

   // Sends all ten words back to back, then one apply pulse.
   task automatic send(input logic [15:0] ctrl, input logic [31:0] spd,
                       input logic [15:0] stp, enc, idl, run, rsvd);
      logic [15:0] w [10];
      w[0] = ctrl;
      w[1] = 16'h0000;
      w[2] = 16'(spd / SPEED_SCALE);
      w[3] = 16'(spd % SPEED_SCALE);
      w[4] = stp;
      w[5] = 16'h0000;
      w[6] = enc;
      w[7] = idl;
      w[8] = run;
      w[9] = rsvd;
      for (int i = 0; i < 10; i++) begin
         @(posedge clk);
         img_wr   <= 1'b1;
         img_addr <= 4'(i);
         img_data <= w[i];
      end
      @(posedge clk);
      img_wr <= 1'b0;
      // One idle edge lets the last word land before the check runs.
      @(posedge clk);
      apply <= 1'b1;
      @(posedge clk);
      apply <= 1'b0;
   endtask : send

   // Rewrites one staged word, then asks for an apply after one idle edge.
   task automatic put(input logic [ADDR_W-1:0] addr,
                      input logic [WORD_W-1:0] data);
      @(posedge clk);
      img_wr   <= 1'b1;
      img_addr <= addr;
      img_data <= data;
      @(posedge clk);
      img_wr <= 1'b0;
      @(posedge clk);
      apply <= 1'b1;
      @(posedge clk);
      apply <= 1'b0;
   endtask : put
endmodule : scfg_host_model

/* File: scfg_image_mem.sv */
`timescale 1ns/100ps
// ------------------------------------------------------------
// Ten-word image store with registered read port.
// ------------------------------------------------------------
module scfg_image_mem (
   // Clock and reset.
   input  wire logic                        clk,
   input  wire logic                        nrst,
   // Write port.
   input  wire logic                        wr_en,
   input  wire logic [scfg_pkg::ADDR_W-1:0] wr_addr,
   input  wire logic [scfg_pkg::WORD_W-1:0] wr_data,
   // Read port.
   input  wire logic [scfg_pkg::ADDR_W-1:0] rd_addr,
   output logic      [scfg_pkg::WORD_W-1:0] rd_data
);
   import scfg_pkg::*;

   typedef struct packed {
      logic [IMAGE_WORDS-1:0][WORD_W-1:0] mem;
      logic [WORD_W-1:0]                  rd;
   } scfg_mem_type;

   scfg_mem_type state;
   scfg_mem_type next_state;

   // Writes beyond the image are dropped; reads there return zero.
   always_comb begin
      next_state = state;
      if (wr_en && (wr_addr < ADDR_W'(IMAGE_WORDS))) begin
         next_state.mem[wr_addr] = wr_data;
      end
      if (rd_addr < ADDR_W'(IMAGE_WORDS)) begin
         next_state.rd = state.mem[rd_addr];
      end else begin
         next_state.rd = WORD_RESET;
      end
   end

   // Registered store.
   always_ff @(posedge clk) begin
      if (!nrst) begin
         state <= '0;
      end else begin
         state <= next_state;
      end
   end

   assign rd_data = state.rd;
endmodule : scfg_image_mem

/* File: scfg_pkg.sv */
package scfg_pkg;
   // ------------------------------------------------------------
   // Image layout.
   // ------------------------------------------------------------
   localparam int unsigned         WORD_W         = 16;
   localparam int unsigned         IMAGE_WORDS    = 10;
   localparam int unsigned         ADDR_W         = 4;
   localparam logic [ADDR_W-1:0]   OFF_CONTROL    = 4'h0;
   localparam logic [ADDR_W-1:0]   OFF_OPTION     = 4'h1;
   localparam logic [ADDR_W-1:0]   OFF_SPEED_UP   = 4'h2;
   localparam logic [ADDR_W-1:0]   OFF_SPEED_LO   = 4'h3;
   localparam logic [ADDR_W-1:0]   OFF_STEPS      = 4'h4;
   localparam logic [ADDR_W-1:0]   OFF_RSVD_A     = 4'h5;
   localparam logic [ADDR_W-1:0]   OFF_ENC_RES    = 4'h6;
   localparam logic [ADDR_W-1:0]   OFF_IDLE_PCT   = 4'h7;
   localparam logic [ADDR_W-1:0]   OFF_RUN_CUR    = 4'h8;
   localparam logic [ADDR_W-1:0]   OFF_RSVD_B     = 4'h9;
   localparam logic [WORD_W-1:0]   WORD_RESET     = 16'h0000;

   // ------------------------------------------------------------
   // Control word field positions.
   // ------------------------------------------------------------
   localparam int unsigned BIT_MODE       = 15;
   localparam int unsigned BIT_RES_OFF    = 14;
   localparam int unsigned BIT_STALL_EN   = 13;
   localparam int unsigned BIT_PROX_GATE  = 11;
   localparam int unsigned BIT_ENC_EN     = 10;
   localparam logic [WORD_W-1:0] CTRL_RSVD_MASK = 16'h13C0;

   // ------------------------------------------------------------
   // Ranges.
   // ------------------------------------------------------------
   localparam logic [WORD_W-1:0] SPEED_SCALE   = 16'h03E8;
   localparam logic [WORD_W-1:0] SPEED_LO_MAX  = 16'h03E7;
   localparam logic [31:0]       SPEED_MIN     = 32'h0000_0001;
   localparam logic [31:0]       SPEED_MAX     = 32'h001E_847F;
   localparam logic [WORD_W-1:0] STEPS_MIN     = 16'h00C8;
   localparam logic [WORD_W-1:0] STEPS_MAX     = 16'h7FFF;
   localparam logic [WORD_W-1:0] ENC_RES_1K    = 16'h0400;
   localparam logic [WORD_W-1:0] ENC_RES_2K    = 16'h0800;
   localparam logic [WORD_W-1:0] ENC_RES_4K    = 16'h1000;
   localparam logic [WORD_W-1:0] IDLE_PCT_MAX  = 16'h0064;
   localparam logic [WORD_W-1:0] RUN_CUR_MIN   = 16'h0001;
   localparam logic [WORD_W-1:0] RUN_CUR_MAX   = 16'h0022;

   // Error flag positions in the status vector.
   localparam int unsigned ERR_W          = 8;
   localparam int unsigned ERR_SPEED      = 0;
   localparam int unsigned ERR_STEPS      = 1;
   localparam int unsigned ERR_ENC_RES    = 2;
   localparam int unsigned ERR_IDLE       = 3;
   localparam int unsigned ERR_RUN_CUR    = 4;
   localparam int unsigned ERR_RESERVED   = 5;
   localparam int unsigned ERR_STALL      = 6;
   localparam int unsigned ERR_SPEED_FMT  = 7;
endpackage : scfg_pkg

/* File: stepper_config_image_decoder_tb_top.sv */
`timescale 1ns/100ps
module stepper_config_image_decoder_tb_top;
   import scfg_pkg::*;

   // ------------------------------------------------------------
   // Signals and rows.
   // ------------------------------------------------------------
   typedef struct packed {
      logic [15:0] ctrl;
      logic [31:0] spd;
      logic [15:0] stp, enc, idl, run;
      logic        ab;
      logic [7:0]  err;
   } scfg_row_type;
   localparam logic [31:0] S1K = 32'h0000_03E8;
   localparam scfg_row_type ROWS [16] = '{
      '{16'h8000, 32'h0000_0001, 16'h00C8, 16'h0, 16'h0, 16'h1, 1'b0, 8'h00},
      '{16'h8000, SPEED_MAX, 16'h7FFF, 16'h0, 16'h64, 16'h22, 1'b0, 8'h00},
      '{16'h8000, 32'h0, 16'h00C8, 16'h0, 16'h0, 16'h1, 1'b0, 8'h01},
      '{16'h8000, 32'h001E_8480, 16'hC8, 16'h0, 16'h0, 16'h1, 1'b0, 8'h01},
      '{16'h8000, S1K, 16'h00C7, 16'h0, 16'h0, 16'h1, 1'b0, 8'h02},
      '{16'h8000, S1K, 16'h8000, 16'h0, 16'h0, 16'h1, 1'b0, 8'h02},
      '{16'h8400, S1K, 16'h00C8, 16'h0400, 16'h0, 16'h1, 1'b0, 8'h00},
      '{16'h8400, S1K, 16'h00C8, 16'h1000, 16'h0, 16'h1, 1'b0, 8'h00},
      '{16'h8400, S1K, 16'h00C8, 16'h03E8, 16'h0, 16'h1, 1'b0, 8'h04},
      '{16'h8400, S1K, 16'h00C8, 16'h0400, 16'h0, 16'h1, 1'b1, 8'h04},
      '{16'h8400, S1K, 16'h00C8, 16'h0800, 16'h0, 16'h1, 1'b1, 8'h00},
      '{16'h8000, S1K, 16'h00C8, 16'h0, 16'h0065, 16'h1, 1'b0, 8'h08},
      '{16'h8000, S1K, 16'h00C8, 16'h0, 16'h0, 16'h0023, 1'b0, 8'h10},
      '{16'h9000, S1K, 16'h00C8, 16'h0, 16'h0, 16'h1, 1'b0, 8'h20},
      '{16'hA000, S1K, 16'h00C8, 16'h0, 16'h0, 16'h1, 1'b0, 8'h40},
      '{16'hE400, S1K, 16'h00C8, 16'h0800, 16'h0, 16'h1, 1'b0, 8'h00}};
   logic        clk, nrst, enc_absolute, prox_flag, home_switch;
   logic        img_wr, apply, config_mode, cfg_valid, cfg_reject;
   logic        resonance_comp_on, stall_detect_on, encoder_on;
   logic        proximity_gate_on_field, home_event;
   logic [3:0]  img_addr, img_rd_addr;
   logic [15:0] img_data, img_rd_data, steps_turn, enc_counts;
   logic [15:0] idle_pct, run_cur;
   logic [7:0]  cfg_errors;
   logic [31:0] start_speed;
   int          bad_count = 0;
   int          tests_run = 0;
   scfg_row_type r;

   scfg_host_model host (.clk(clk), .img_wr(img_wr), .img_addr(img_addr),
                         .img_data(img_data), .apply(apply));

   scfg_decoder uut (.clk(clk), .nrst(nrst), .img_wr(img_wr),
      .img_addr(img_addr), .img_data(img_data), .img_rd_addr(img_rd_addr),
      .img_rd_data(img_rd_data), .apply(apply), .enc_absolute(enc_absolute),
      .prox_flag(prox_flag), .home_switch(home_switch),
      .config_mode(config_mode), .cfg_valid(cfg_valid),
      .cfg_reject(cfg_reject), .cfg_errors(cfg_errors),
      .resonance_comp_on(resonance_comp_on),
      .stall_detect_on(stall_detect_on), .encoder_on(encoder_on),
      .proximity_gate_on_field(proximity_gate_on_field),
      .start_speed(start_speed), .steps_turn(steps_turn),
      .enc_counts(enc_counts), .idle_pct(idle_pct), .run_cur(run_cur),
      .home_event(home_event));

   // ------------------------------------------------------------
   // Checking tasks.
   // ------------------------------------------------------------
   task automatic chk_bit(input logic got, input logic exp);
      tests_run++;
      if (got !== exp) begin
         bad_count++;
         $display("CHECK FAILED at %0t: flag %b, expected %b",
                  $time, got, exp);
      end
   endtask : chk_bit

   task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         bad_count++;
         $display("CHECK FAILED at %0t: value %h, expected %h",
                  $time, got, exp);
      end
   endtask : chk_val

   // Outputs are read two full cycles after the apply edge has landed.
   task automatic settle();
      repeat (2) @(posedge clk);
      #1;
   endtask : settle

   // Raises the switch once and counts qualified home pulses.
   task automatic home_try(input int exp);
      int n;
      n = 0;
      @(posedge clk);
      home_switch <= 1'b1;
      repeat (8) begin
         @(posedge clk);
         #1;
         if (home_event === 1'b1) n++;
      end
      @(posedge clk);
      home_switch <= 1'b0;
      repeat (8) @(posedge clk);
      chk_val(32'(n), 32'(exp));
   endtask : home_try

   task automatic final_report();
      $display("Checks run %0d, mismatches %0d", tests_run, bad_count);
      if (bad_count == 0 && tests_run > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : final_report

   // ------------------------------------------------------------
   // Clock, watchdog and main sequence.
   // ------------------------------------------------------------
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   // A full run needs well under a thousand cycles per scenario.
   initial begin
      repeat (20000) @(posedge clk);
      bad_count++;
      final_report();
   end

   // Table rows first, then refusals and homing by hand.
   initial begin
      nrst         = 1'b0;
      enc_absolute = 1'b0;
      prox_flag    = 1'b0;
      home_switch  = 1'b0;
      img_rd_addr  = 4'h3;
      repeat (12) @(posedge clk);
      nrst <= 1'b1;
      #1;
      chk_bit(config_mode, 1'b0);
      chk_bit(resonance_comp_on, 1'b1);
      chk_bit(cfg_valid, 1'b0);
      for (int i = 0; i < 16; i++) begin
         r = ROWS[i];
         @(posedge clk);
         enc_absolute <= r.ab;
         host.send(r.ctrl, r.spd, r.stp, r.enc, r.idl, r.run, 16'h0000);
         settle();
         chk_bit(config_mode, 1'b1);
         chk_val(cfg_errors, r.err);
         chk_bit(cfg_reject, r.err != 8'h00);
         if (r.err == 8'h00) begin
            chk_val(start_speed, r.spd);
            chk_val(steps_turn, r.stp);
            chk_val(idle_pct, r.idl);
            chk_val(run_cur, r.run);
            chk_bit(resonance_comp_on, !r.ctrl[14]);
            chk_bit(stall_detect_on, r.ctrl[13]);
            chk_bit(encoder_on, r.ctrl[10]);
            if (r.ctrl[10]) chk_val(enc_counts, r.enc);
         end
      end
      @(posedge clk);
      enc_absolute <= 1'b0;
      host.send(16'h8000, S1K, 16'h00C8, 16'h0, 16'h0, 16'h1, 16'h1);
      settle();
      chk_val(cfg_errors, 8'h20);
      chk_bit(cfg_valid, 1'b1);
      // A good image sent in command mode must not be adopted.
      host.send(16'h0000, S1K, 16'h00C8, 16'h0, 16'h0, 16'h1, 16'h0);
      settle();
      chk_bit(config_mode, 1'b0);
      chk_bit(cfg_reject, 1'b1);
      host.send(16'h8800, 32'h0000_3039, 16'hC8, 16'h0, 16'h0, 16'h1, 16'h0);
      settle();
      chk_bit(proximity_gate_on_field, 1'b1);
      chk_val(img_rd_data, 16'h0159);
      home_try(0);
      prox_flag <= 1'b1;
      home_try(1);
      host.send(16'h8000, S1K, 16'h00C8, 16'h0, 16'h0, 16'h1, 16'h0);
      @(posedge clk);
      prox_flag <= 1'b0;
      settle();
      chk_bit(proximity_gate_on_field, 1'b0);
      home_try(1);
      // A lower word above 999 is malformed even when the sum is legal.
      host.put(OFF_SPEED_LO, 16'h03E8);
      settle();
      chk_val(cfg_errors, 8'h80);
      chk_val(start_speed, S1K);
      chk_val(img_rd_data, 16'h03E8);
      // A reset in mid-run must drop everything that an apply adopted.
      @(posedge clk);
      nrst <= 1'b0;
      repeat (2) @(posedge clk);
      nrst <= 1'b1;
      #1;
      chk_bit(config_mode, 1'b0);
      chk_bit(resonance_comp_on, 1'b1);
      chk_bit(cfg_valid, 1'b0);
      chk_bit(cfg_reject, 1'b0);
      chk_val(cfg_errors, 8'h00);
      chk_val(start_speed, 32'h0000_0000);
      chk_bit(proximity_gate_on_field, 1'b0);
      final_report();
   end
endmodule : stepper_config_image_decoder_tb_top
